// File: shared/sbiu_pkg.sv
// Package for the serial board interrupt unit: register locations, field
// positions, reset values, the priority algorithm type and the source bundle.
// Assumes a single clock and a classic Wishbone slave with 32-bit data.
//
// Notes on behaviour
// R1 - Two eight-level units serve sixteen levels.
// R2 - Fully nested: level 0 highest, 7 lowest.
// R3 - Rotating: serviced level drops to lowest priority.
// R4 - Specific: software names lowest, others follow numerically.
// R5 - Algorithm and assignment change any time.
// R6 - Each unit has a one-byte mask register.
// R7 - Each unit request routes to one of nine lines.
// R8 - Each channel has enabled receive and transmit requests.
// R9 - Unit 0 level 2n receive, 2n+1 transmit.
// R10 - Unit 1 levels 0,1 take enabled counters.
// R11 - Unit 1: ring 2, digit 3, carrier 4-7.
// R12 - All registers decode as sixteen I/O locations.
// R13 - Block base is any multiple of sixteen.
// R14 - Host writes sixteen-bit bit-rate divisors by software.
// R15 - Counter raises request on reaching terminal count.
// R16 - Masked requests wait, then present when unmasked.
// R17 - Only the highest ranked pending request presented.
package sbiu_pkg;

  // Priority algorithm of one unit; the fourth code is illegal.
  typedef enum logic [1:0] {
    SBIU_NESTED,
    SBIU_ROTATE,
    SBIU_SPECIFIC
  } sbiu_mode_t;

  // Request sources arriving from the serial, modem and dialer logic.
  typedef struct packed {
    logic [3:0] rx_full;
    logic [3:0] tx_empty;
    logic [3:0] ring;
    logic       next_digit;
    logic [3:0] carrier;
  } sbiu_src_t;

  // Sizes.
  localparam int          SBIU_LEVELS    = 8;
  localparam int          SBIU_BUS_LINES = 9;
  localparam int          SBIU_CNT_W     = 16;
  localparam int          SBIU_ADR_W     = 18;
  localparam int          SBIU_BASE_W    = 12;

  // Register locations inside the sixteen-location block.
  localparam logic [3:0]  LOC_U0_MASK   = 4'h0;
  localparam logic [3:0]  LOC_U0_CTRL   = 4'h1;
  localparam logic [3:0]  LOC_U0_STAT   = 4'h2;
  localparam logic [3:0]  LOC_U0_DONE   = 4'h3;
  localparam logic [3:0]  LOC_U1_MASK   = 4'h4;
  localparam logic [3:0]  LOC_U1_CTRL   = 4'h5;
  localparam logic [3:0]  LOC_U1_STAT   = 4'h6;
  localparam logic [3:0]  LOC_U1_DONE   = 4'h7;
  localparam logic [3:0]  LOC_SRC_EN    = 4'h8;
  localparam logic [3:0]  LOC_CNT1      = 4'h9;
  localparam logic [3:0]  LOC_CNT2      = 4'ha;
  localparam logic [3:0]  LOC_CNT_STAT  = 4'hb;
  localparam logic [3:0]  LOC_EV_STAT   = 4'hc;
  localparam logic [3:0]  LOC_EV_MASK   = 4'hd;

  // Field positions.
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_LOW_LSB  = 4;
  localparam int          STAT_ACT_BIT  = 8;
  localparam int          STAT_LVL_LSB  = 9;
  localparam int          SRC_RX_LSB    = 0;
  localparam int          SRC_TX_LSB    = 4;
  localparam int          SRC_CNT_LSB   = 8;
  localparam int          EV_CNT_LSB    = 0;
  localparam int          EV_UNIT_LSB   = 2;

  // Reset values.
  localparam logic [7:0]  RST_MASK      = 8'hff;
  localparam logic [1:0]  RST_MODE      = 2'h0;
  localparam logic [2:0]  RST_LOWEST    = 3'h7;
  localparam logic [9:0]  RST_SRC_EN    = 10'h000;
  localparam logic [15:0] RST_COUNT     = 16'h0000;
  localparam logic [3:0]  RST_EV        = 4'h0;

endpackage

// File: src/sbiu_prio_unit.sv
// One eight-level priority unit: masking and ranking of level requests.
// Assumes level-sensitive requests that stay high until serviced.
`timescale 1ns/1ps
module sbiu_prio_unit import sbiu_pkg::*; #(
  parameter int LEVELS = SBIU_LEVELS,
  parameter int LW     = $clog2(SBIU_LEVELS)
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [LEVELS-1:0] req_i,
  input  wire logic [LEVELS-1:0] mask_i,
  input  wire logic [1:0]        mode_i,
  input  wire logic [LW-1:0]     lowest_i,
  input  wire logic              done_i,
  input  wire logic [LW-1:0]     done_level_i,
  output logic                   active_o,
  output logic [LW-1:0]          level_o
);

  logic [LW-1:0]     rot_low_r;
  logic [LW-1:0]     base;
  logic [LEVELS-1:0] live;

  // R3 rotating lowest: a serviced level becomes lowest until the next one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rot_low_r <= RST_LOWEST;
    end else if (done_i) begin
      rot_low_r <= done_level_i;
    end
  end

  // R16 mask gating: masked requests are held back, not forgotten.
  assign live = req_i & ~mask_i;

  // The lowest ranked level for the current algorithm, read every cycle so
  // a change from software takes effect at once.
  // R5 live reconfiguration
  always_comb begin
    unique case (sbiu_mode_t'(mode_i))
      // R2 fixed order
      SBIU_NESTED:   base = LW'(LEVELS - 1);
      SBIU_ROTATE:   base = rot_low_r;
      // R4 software lowest
      SBIU_SPECIFIC: base = lowest_i;
      default:       base = LW'(LEVELS - 1);
    endcase
  end

  // Search upward from just above the lowest level, wrapping round, and
  // keep the first live level found as the winner.
  // R17 single winner
  always_comb begin
    logic [LW-1:0] idx;
    logic          found;
    idx      = '0;
    found    = 1'b0;
    level_o  = '0;
    for (int k = 1; k <= LEVELS; k++) begin
      idx = base + LW'(k);
      if (!found && live[idx]) begin
        found   = 1'b1;
        level_o = idx;
      end
    end
    active_o = found;
  end

endmodule

// File: src/sbiu_top.sv
// Interrupt collection for a four channel serial board: two priority units,
// two interval counters, request routing to nine bus lines, and a Wishbone
// register block. Assumes one clock, synchronous sources and a single
// classic Wishbone master.
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module sbiu_top import sbiu_pkg::*; #(
  parameter int ADR_W  = SBIU_ADR_W,
  parameter int BASE_W = SBIU_BASE_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADR_W-1:0]  adr_i,
  input  wire logic [31:0]       dat_i,
  output logic [31:0]            dat_o,
  input  wire logic              we_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  output logic                   ack_o,
  input  wire logic [BASE_W-1:0] base_sel_i,
  input  wire logic [3:0]        route0_i,
  input  wire logic [3:0]        route1_i,
  input  wire sbiu_src_t         src_i,
  output logic [SBIU_BUS_LINES-1:0] bus_int_o,
  output logic                   irq_o
);

  // Bus side state. Acknowledge and read data come from flip-flops, so the
  // master sees settled values for the whole answer cycle.
  logic        ack_r;
  logic [31:0] dat_r;
  logic        req;
  logic        hit;
  logic        wr;
  logic [3:0]  loc;
  logic [31:0] lane;

  // Per unit state. Index 0 is the serial channel unit and index 1 the
  // modem, dialer and counter unit; the arrays keep the logic of the two
  // units written once for both.
  logic [7:0]  mask_r   [2];
  logic [1:0]  mode_r   [2];
  logic [2:0]  lowest_r [2];
  logic        done     [2];
  logic        active   [2];
  logic [2:0]  level    [2];
  logic [7:0]  unit_req [2];
  logic [9:0]  src_en_r;
  logic [SBIU_CNT_W-1:0] count_r [2];
  logic [1:0]  tc_r;
  logic [1:0]  tc_set;
  logic [3:0]  ev_r;
  logic [3:0]  ev_mask_r;
  logic [3:0]  ev_set;
  logic [1:0]  act_d_r;
  logic [SBIU_BUS_LINES-1:0] bus_nxt;

  // Bus request decode. The I/O location is the word index of the byte
  // address; reads and writes reach the block only when its upper bits match the base.
  // Only word addresses are decoded; the two low address bits are ignored
  // and the byte lanes pick the bytes instead.
  // R12 sixteen-location block
  assign req = cyc_i & stb_i;
  assign loc = adr_i[5:2];
  // R13 static base
  assign hit = (adr_i[ADR_W-1:6] == base_sel_i);
  // Writes and write side effects happen on the edge that samples ack.
  assign wr  = req & ack_r & we_i & hit;

  // The enable register uses the lanes and the counters use lanes 0 and 1; the rest decode lane 0.
  // Byte lanes enabled by the select bits.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      lane[8*b +: 8] = {8{sel_i[b]}};
    end
  end

  // Acknowledge one cycle after the strobe, then drop it for a cycle so
  // that every access ends before another is taken. Unmatched addresses
  // are still acknowledged so the master never hangs.
  // The idle cycle halves the peak access rate, but it keeps the take
  // condition to one gate and stops a held strobe being taken twice.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end
  assign ack_o = ack_r;

  // Read data is captured when the access is taken and held through ack.
  // Status reads sample the ranking at the take edge, so a request that
  // changes during the answer cycle shows in the next read instead.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (req & ~ack_r) begin
      dat_r <= 32'h0000_0000;
      if (hit && !we_i) begin
        unique case (loc)
          LOC_U0_MASK:  dat_r[7:0] <= mask_r[0];
          LOC_U1_MASK:  dat_r[7:0] <= mask_r[1];
          LOC_U0_CTRL: begin
            dat_r[CTRL_MODE_LSB +: 2] <= mode_r[0];
            dat_r[CTRL_LOW_LSB +: 3]  <= lowest_r[0];
          end
          LOC_U1_CTRL: begin
            dat_r[CTRL_MODE_LSB +: 2] <= mode_r[1];
            dat_r[CTRL_LOW_LSB +: 3]  <= lowest_r[1];
          end
          LOC_U0_STAT: begin
            dat_r[7:0]               <= unit_req[0];
            dat_r[STAT_ACT_BIT]      <= active[0];
            dat_r[STAT_LVL_LSB +: 3] <= level[0];
          end
          LOC_U1_STAT: begin
            dat_r[7:0]               <= unit_req[1];
            dat_r[STAT_ACT_BIT]      <= active[1];
            dat_r[STAT_LVL_LSB +: 3] <= level[1];
          end
          LOC_SRC_EN:   dat_r[9:0]  <= src_en_r;
          LOC_CNT1:     dat_r[15:0] <= count_r[0];
          LOC_CNT2:     dat_r[15:0] <= count_r[1];
          LOC_CNT_STAT: dat_r[1:0]  <= tc_r;
          LOC_EV_STAT:  dat_r[3:0]  <= ev_r;
          LOC_EV_MASK:  dat_r[3:0]  <= ev_mask_r;
          default:      dat_r       <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign dat_o = dat_r;

  // Mask registers, one byte each, written with any combination of bits.
  // A level masked while it requests is not forgotten: its source still
  // holds it, and it competes again as soon as its mask bit clears.
  // R6 mask byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r[0] <= RST_MASK;
      mask_r[1] <= RST_MASK;
    end else if (wr && sel_i[0]) begin
      if (loc == LOC_U0_MASK) begin
        mask_r[0] <= dat_i[7:0];
      end
      if (loc == LOC_U1_MASK) begin
        mask_r[1] <= dat_i[7:0];
      end
    end
  end

  // Algorithm and lowest level, writable at any time while running.
  // A new algorithm applies to the ranking in the cycle after the write,
  // and no pending request is dropped by the change.
  // R5 live reconfiguration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r[0]   <= RST_MODE;
      mode_r[1]   <= RST_MODE;
      lowest_r[0] <= RST_LOWEST;
      lowest_r[1] <= RST_LOWEST;
    end else if (wr && sel_i[0]) begin
      if (loc == LOC_U0_CTRL) begin
        mode_r[0]   <= dat_i[CTRL_MODE_LSB +: 2];
        lowest_r[0] <= dat_i[CTRL_LOW_LSB +: 3];
      end
      if (loc == LOC_U1_CTRL) begin
        mode_r[1]   <= dat_i[CTRL_MODE_LSB +: 2];
        lowest_r[1] <= dat_i[CTRL_LOW_LSB +: 3];
      end
    end
  end

  // Software reports a serviced level by writing it to the done location.
  // The level rides on the write data. A done write in another mode is
  // harmless: it only moves the rotating bottom for later use.
  assign done[0] = wr & sel_i[0] & (loc == LOC_U0_DONE);
  assign done[1] = wr & sel_i[0] & (loc == LOC_U1_DONE);

  // Per-source enables for receive, transmit and counter requests.
  // Each byte lane updates only its own enables, so software can change
  // the counter enables without disturbing the channel enables.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_en_r <= RST_SRC_EN;
    end else if (wr && loc == LOC_SRC_EN) begin
      src_en_r <= (src_en_r & ~lane[9:0]) | (dat_i[9:0] & lane[9:0]);
    end
  end

  // Interval counters. A write loads the count and clears terminal count;
  // the counter then runs down once per clock and stops at zero, where its
  // request rises and stays until the next load.
  // Limitation: counting is binary at the board clock only, and a load of
  // zero raises terminal count on the very next edge.
  // R15 terminal count request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r[0] <= RST_COUNT;
      count_r[1] <= RST_COUNT;
      tc_r       <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wr && loc == (LOC_CNT1 + 4'(c))) begin
          count_r[c][7:0]  <= sel_i[0] ? dat_i[7:0] : count_r[c][7:0];
          count_r[c][15:8] <= sel_i[1] ? dat_i[15:8] : count_r[c][15:8];
          tc_r[c]          <= 1'b0;
        end else if (count_r[c] != RST_COUNT) begin
          count_r[c] <= count_r[c] - 16'h0001;
        end else begin
          tc_r[c] <= 1'b1;
        end
      end
    end
  end

  // Terminal count events are the rising edges of the counter requests.
  // The load term hides the cycle in which a load keeps the request from rising.
  assign tc_set = ~tc_r & {count_r[1] == RST_COUNT, count_r[0] == RST_COUNT}
                  & ~{wr && loc == LOC_CNT2, wr && loc == LOC_CNT1};

  // Unit 0 takes each channel's receive request on the even level and its
  // transmit request on the odd level above it, each gated by its enable.
  // R8 channel enables
  // R9 unit 0 pairing
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      unit_req[0][2*n]   = src_i.rx_full[n]  & src_en_r[SRC_RX_LSB + n];
      unit_req[0][2*n+1] = src_i.tx_empty[n] & src_en_r[SRC_TX_LSB + n];
    end
  end

  // Unit 1 takes the counters, the combined ring, the dialer and carriers.
  // R10 counter levels
  assign unit_req[1][1:0] = tc_r & src_en_r[SRC_CNT_LSB +: 2];
  // R11 modem levels
  assign unit_req[1][2]   = |src_i.ring;
  assign unit_req[1][3]   = src_i.next_digit;
  assign unit_req[1][7:4] = src_i.carrier;

  // Two identical priority units give the sixteen levels.
  // Both units see the done level lane; only the addressed one takes it.
  // The units share no state, so either can be reconfigured alone.
  // R1 two units
  for (genvar u = 0; u < 2; u++) begin : g_unit
    sbiu_prio_unit #(
      .LEVELS (SBIU_LEVELS)
    ) u_prio (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .req_i        (unit_req[u]),
      .mask_i       (mask_r[u]),
      .mode_i       (mode_r[u]),
      .lowest_i     (lowest_r[u]),
      .done_i       (done[u]),
      .done_level_i (dat_i[2:0]),
      .active_o     (active[u]),
      .level_o      (level[u])
    );
  end

  // Route each unit's request to the bus line its strap selects. A strap
  // value past the last line leaves that unit disconnected.
  // Two units strapped to one line share it as a wired or.
  // R7 line routing
  always_comb begin
    bus_nxt = '0;
    for (int l = 0; l < SBIU_BUS_LINES; l++) begin
      if ((route0_i == 4'(l) && active[0]) ||
          (route1_i == 4'(l) && active[1])) begin
        bus_nxt[l] = 1'b1;
      end
    end
  end

  // Bus lines come from flip-flops so they never glitch on the backplane.
  // The price is one cycle from a source change to its line, which also
  // keeps the ranking search chain off the backplane timing path.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_int_o <= '0;
    end else begin
      bus_int_o <= bus_nxt;
    end
  end

  // Previous unit activity, used to find new requests.
  // It resets low, like an idle unit, so no false event follows reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_d_r <= 2'b00;
    end else begin
      act_d_r <= {active[1], active[0]};
    end
  end

  // Events for the local interrupt: counter terminal counts and each unit
  // starting to request.
  // A source that stays high raises one unit event, not one per cycle;
  // software clears it once and then sees only the next new request.
  assign ev_set = {{active[1], active[0]} & ~act_d_r, tc_set};

  // Sticky event status, cleared by writing ones. A new event in the same
  // cycle as its clear keeps the bit set, so nothing is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_r <= RST_EV;
    end else if (wr && loc == LOC_EV_STAT && sel_i[0]) begin
      ev_r <= (ev_r & ~dat_i[3:0]) | ev_set;
    end else begin
      ev_r <= ev_r | ev_set;
    end
  end

  // Event mask, same layout as the status; a one lets the bit through.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_mask_r <= RST_EV;
    end else if (wr && loc == LOC_EV_MASK && sel_i[0]) begin
      ev_mask_r <= dat_i[3:0];
    end
  end

  // Level interrupt while any unmasked event bit is set.
  // Masking acts after the status, so masked events stay visible to a
  // polling routine.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(ev_r & ev_mask_r);
    end
  end

endmodule

// File: tb/sbiu_host_model.sv
// Host bus master standing in for the processor and its software.
// Assumes a classic single-cycle Wishbone slave on the same clock.
`timescale 1ns/1ps
module sbiu_host_model (
  input  wire logic clk_i,
  input  wire logic ack_i,
  output logic      cyc_o,
  output logic      stb_o,
  output logic      we_o,
  output logic [3:0]  sel_o,
  output logic [17:0] adr_o,
  output logic [31:0] dat_o,
  output logic      hang_o
);
  // Idle bus at time zero; hang_o marks an answer that never came.
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    sel_o = 4'h0;
    adr_o = 18'h0;
    dat_o = 32'h0;
    hang_o = 1'b0;
  end

  // whole word accesses
  // All lanes go out together, so a 16-bit count is never split.
  // Released lines carry the inverse so stale values cannot pass.
  task automatic acc(input logic w, input logic [17:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    sel_o <= 4'hf;
    adr_o <= a;
    dat_o <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 16);
    if (ack_i !== 1'b1) hang_o <= 1'b1;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule

// File: tb/sbiu_props.sv
// Checker for the interrupt unit: bus answers, line routing, interrupt.
// Assumes it is bound to sbiu_top and sees only that module's ports.
`timescale 1ns/1ps
module sbiu_props import sbiu_pkg::*; #(
  parameter int ADR_W  = SBIU_ADR_W,
  parameter int BASE_W = SBIU_BASE_W
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic [ADR_W-1:0]  adr_i,
  input wire logic [31:0]       dat_i,
  input wire logic [31:0]       dat_o,
  input wire logic              we_i,
  input wire logic [3:0]        sel_i,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              ack_o,
  input wire logic [BASE_W-1:0] base_sel_i,
  input wire logic [3:0]        route0_i,
  input wire logic [3:0]        route1_i,
  input wire sbiu_src_t         src_i,
  input wire logic [8:0]        bus_int_o,
  input wire logic              irq_o
);
  logic       req;
  logic       hit;
  logic [8:0] used;

  // Lines strapped to a unit; a strap above 8 routes nowhere.
  always_comb begin
    req = cyc_i & stb_i;
    hit = (adr_i[ADR_W-1:6] == base_sel_i);
    used = '0;
    if (route0_i < 4'h9) used[route0_i] = 1'b1;
    if (route1_i < 4'h9) used[route1_i] = 1'b1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_answer: assert property (req && !ack_o |=> ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(req) && req)
    else $error("ack without a request");
  a_read_zero: assert property (ack_o && !we_i && req &&
      (!hit || adr_i[5:2] > 4'hd) |-> dat_o == 32'h0)
    else $error("foreign or unmapped read not zero");
  a_dat_hold: assert property (!(req && !ack_o) |=> $stable(dat_o))
    else $error("read data moved without an access");
  a_route_only: assert property ((bus_int_o & ~used) == 9'h0)
    else $error("request on an unrouted bus line");
  a_unit0_idle: assert property (
      src_i.rx_full == 4'h0 && src_i.tx_empty == 4'h0 &&
      route0_i < 4'h9 && route1_i != route0_i |=> !bus_int_o[route0_i])
    else $error("unit 0 line high with no source");
  a_irq_off: assert property (ack_o && we_i && req && hit &&
      adr_i[5:2] == LOC_EV_MASK && sel_i[0] && dat_i[3:0] == 4'h0
      |-> ##2 !irq_o)
    else $error("interrupt high with all events masked");
  a_rst_quiet: assert property (disable iff (1'b0)
      rst_i |=> !ack_o && !irq_o && bus_int_o == 9'h0)
    else $error("outputs active during reset");
endmodule

bind sbiu_top sbiu_props #(.ADR_W(ADR_W), .BASE_W(BASE_W)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
  .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .base_sel_i(base_sel_i),
  .route0_i(route0_i), .route1_i(route1_i), .src_i(src_i),
  .bus_int_o(bus_int_o), .irq_o(irq_o)
);

// File: tb/tb_top.sv
// Self-checking bench: registers, ranking, routing, counters, interrupt.
// Assumes the host model speaks the bus and sources are synchronous.
`timescale 1ns/1ps
module tb_top import sbiu_pkg::*;;
  typedef struct {
    logic [31:0] e;
    logic [31:0] m;
  } sbiu_exp_t;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq, hang;
  logic [3:0]  sel, route0, route1;
  logic [17:0] adr;
  logic [31:0] wdat, rdat, e;
  logic [11:0] base;
  logic [8:0]  bus_int;
  sbiu_src_t   src, s;
  sbiu_exp_t   q[$], ex;
  int          n_fail = 0;
  int          n_compared = 0;
  int          seed = 32'h215e88a0;

  sbiu_top u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .dat_o(rdat),
    .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
    .base_sel_i(base), .route0_i(route0), .route1_i(route1),
    .src_i(src), .bus_int_o(bus_int), .irq_o(irq)
  );
  sbiu_host_model u_host (
    .clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .sel_o(sel), .adr_o(adr), .dat_o(wdat), .hang_o(hang)
  );

  // Free-running 50 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [17:0] at(input logic [3:0] l);
    return {base, l, 2'b00};
  endfunction

  // Winner search starts one above the lowest level and wraps round.
  function automatic logic [31:0] stat(input logic [7:0] r,
                                       input logic [2:0] low);
    logic [2:0] k;
    stat = 32'h0;
    for (int i = 1; i <= 8; i++) begin
      k = low + 3'(i);
      if (r[k] && !stat[8]) stat[11:8] = {k, 1'b1};
    end
  endfunction

  task automatic chk(input string nm, input logic [31:0] x, g);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic wr(input logic [3:0] l, input logic [31:0] d);
    u_host.acc(1'b1, at(l), d);
  endtask

  // The note goes in before the request so the watcher always finds it.
  task automatic rd(input logic [17:0] a, input logic [31:0] x, m);
    q.push_back('{x, m});
    u_host.acc(1'b0, a, 32'h0);
  endtask

  task automatic final_report();
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Read data is judged at the edge where ack is sampled; a hang ends it.
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
      ex = q.pop_front();
      chk("read data", ex.e & ex.m, rdat & ex.m);
    end
    if (hang === 1'b1) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    logic [7:0] r, mk;
    logic [2:0] low;
    logic [1:0] m;
    int n;
    rst_i = 1'b1;
    src = '0;
    base = 12'($random(seed));
    route0 = 4'($unsigned($random(seed)) % 9);
    route1 = 4'((route0 + 1 + $unsigned($random(seed)) % 8) % 9);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(at(LOC_U0_MASK), 32'hff, 32'hff);
    rd(at(LOC_U1_CTRL), 32'h70, 32'h73);
    rd(at(4'he), 32'h0, 32'hffffffff);
    rd({~base, LOC_U0_MASK, 2'b00}, 32'h0, 32'hffffffff);
    // Random requests and masks, and a fixed cycle of modes with no rotation, change while unit 0 runs.
    wr(LOC_SRC_EN, 32'hff);
    for (n = 0; n < 12; n++) begin
      r = 8'($random(seed));
      mk = 8'($random(seed)) & 8'($random(seed));
      low = 3'($random(seed));
      m = 2'(n % 4);
      if (m == 2'h1) m = 2'h2;
      @(posedge clk_i);
      src.rx_full <= {r[6], r[4], r[2], r[0]};
      src.tx_empty <= {r[7], r[5], r[3], r[1]};
      wr(LOC_U0_MASK, {24'h0, mk});
      wr(LOC_U0_CTRL, {25'h0, low, 2'h0, m});
      e = stat(r & ~mk, (m == 2'h2) ? low : 3'h7);
      rd(at(LOC_U0_STAT), e, e[8] ? 32'hf00 : 32'h100);
      chk("unit0 line", {31'h0, e[8]}, {31'h0, bus_int[route0]});
    end
    // Rotation: the level just serviced falls to the bottom.
    // Every level of unit 0 requests, so the winner is the one above bottom.
    @(posedge clk_i);
    src.rx_full <= 4'hf;
    src.tx_empty <= 4'hf;
    wr(LOC_U0_MASK, 32'h0);
    wr(LOC_U0_CTRL, 32'h1);
    for (n = 0; n < 4; n++) begin
      low = 3'($random(seed));
      wr(LOC_U0_DONE, {29'h0, low});
      rd(at(LOC_U0_STAT), {20'h0, low + 3'h1, 1'b1, 8'h0}, 32'hf00);
    end
    // Modem and dialer levels of unit 1, with the level 7 carrier always pending.
    wr(LOC_U1_MASK, 32'h0);
    for (n = 0; n < 6; n++) begin
      s = '0;
      s.carrier = 4'h8;
      if (n == 0) s.ring = 4'h1 << ($unsigned($random(seed)) % 4);
      else if (n == 1) s.next_digit = 1'b1;
      else s.carrier = s.carrier | (4'h1 << (n - 2));
      @(posedge clk_i);
      src <= s;
      e = {20'h0, 3'(n < 2 ? n + 2 : n + 2), 1'b1, 8'h0};
      rd(at(LOC_U1_STAT), e, 32'hf00);
      chk("unit1 line", 32'h1, {31'h0, bus_int[route1]});
    end
    // Counters reload, run down and raise the masked event interrupt.
    @(posedge clk_i);
    src <= '0;
    wr(LOC_CNT1, 32'h30);
    wr(LOC_CNT2, 32'h38);
    wr(LOC_EV_STAT, 32'hf);
    wr(LOC_EV_MASK, 32'h1);
    wr(LOC_SRC_EN, 32'h300);
    rd(at(LOC_U1_STAT), 32'h0, 32'h100);
    for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk_i);
    chk("irq raise", 32'h1, {31'h0, irq});
    rd(at(LOC_U1_STAT), 32'h100, 32'hf00);
    repeat (10) @(posedge clk_i);
    rd(at(LOC_EV_STAT), 32'hb, 32'hf);
    wr(LOC_SRC_EN, 32'h200);
    rd(at(LOC_U1_STAT), 32'h300, 32'hf00);
    wr(LOC_EV_STAT, 32'h1);
    repeat (3) @(posedge clk_i);
    chk("irq clear", 32'h0, {31'h0, irq});
    wr(LOC_EV_MASK, 32'h2);
    repeat (3) @(posedge clk_i);
    chk("irq unmask", 32'h1, {31'h0, irq});
    wr(LOC_EV_MASK, 32'h0);
    repeat (3) @(posedge clk_i);
    chk("irq mask", 32'h0, {31'h0, irq});
    // A second reset in mid-run restores masks and the nested algorithm.
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(at(LOC_U0_MASK), 32'hff, 32'hff);
    rd(at(LOC_U0_CTRL), 32'h70, 32'h73);
    // Let the watcher judge the last read before the run ends.
    repeat (2) @(posedge clk_i);
    final_report();
  end
endmodule
